// ===== hdl/vpc_regs.sv
// register set and command interpreter of the two-channel sound playback processor
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "vpc_map.svh"

module vpc_regs #(
  parameter int GAP_CYCLES = `VPC_GAP_MS * `VPC_CLK_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rd_data,
  // synthesis engine
  input wire logic [1:0] phrase_end,
  output logic [1:0] phrase_start,
  output logic [15:0] ch0_phrase,
  output logic [15:0] ch1_phrase,
  output logic [7:0] ch0_level,
  output logic [7:0] ch1_level,
  output logic [1:0] gapless,
  output logic output_active_flag,
  // events
  output logic transition_evt,
  output logic error_evt
);
  import vpc_pkg::*;

  vpc_state_t q;
  vpc_state_t n;
  logic execute;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  function automatic logic on_grid(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    logic [15:0] d;
    d = v - lo;
    on_grid = (v >= lo) && (v <= hi) && ((d % `VPC_RATE_STEP) == 16'h0000);
  endfunction

  function automatic logic rates_ok(input logic [15:0] sp, input logic [15:0] pt);
    if (pt == 16'h0000)
      rates_ok = (sp == 16'h0000) || on_grid(sp, `VPC_RATE_WIDE_LO, `VPC_RATE_WIDE_HI);
    else if (sp == 16'h0000)
      rates_ok = on_grid(pt, `VPC_RATE_WIDE_LO, `VPC_RATE_WIDE_HI);
    else
      rates_ok = on_grid(sp, `VPC_SPEED_PAIR_LO, `VPC_SPEED_PAIR_HI)
        && on_grid(pt, `VPC_PITCH_PAIR_LO, `VPC_PITCH_PAIR_HI);
  endfunction

  assign execute = (q.busy_cnt == 3'h1);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [15:0] e;
    logic ok;
    e = 16'h0000;
    ok = 1'b0;
    n = q;
    n.rd_data = 32'h0000_0000;
    n.start = 2'b00;
    n.evt = 1'b0;
    n.err_evt = 1'b0;

    if (rd)
    begin
      case (addr)
        `VPC_OFF_FUNC: n.rd_data = {16'h0000, q.func};
        `VPC_OFF_MASK: n.rd_data = {16'h0000, q.mask};
        `VPC_OFF_ROM_START_ADDRESS: n.rd_data = q.rom_start_address;
        `VPC_OFF_ROM_BYTE_SIZE: n.rd_data = q.rom_byte_size;
        `VPC_OFF_KEY: n.rd_data = q.key;
        `VPC_OFF_CMD0: n.rd_data = {16'h0000, q.cmd[0]};
        `VPC_OFF_CMD1: n.rd_data = {16'h0000, q.cmd[1]};
        `VPC_OFF_SENT0: n.rd_data = {16'h0000, q.sent[0]};
        `VPC_OFF_SENT1: n.rd_data = {16'h0000, q.sent[1]};
        `VPC_OFF_VOL0: n.rd_data = {16'h0000, q.vol[0]};
        `VPC_OFF_VOL1: n.rd_data = {16'h0000, q.vol[1]};
        `VPC_OFF_REP0: n.rd_data = {16'h0000, q.rep[0]};
        `VPC_OFF_REP1: n.rd_data = {16'h0000, q.rep[1]};
        `VPC_OFF_SPEED: n.rd_data = {16'h0000, q.speed};
        `VPC_OFF_PITCH: n.rd_data = {16'h0000, q.pitch};
        `VPC_OFF_STATE0: n.rd_data = {29'h0000_0000, q.st[0]};
        `VPC_OFF_STATE1: n.rd_data = {29'h0000_0000, q.st[1]};
        `VPC_OFF_ERROR: n.rd_data = {16'h0000, q.err};
        `VPC_OFF_STATUS:
        begin
          n.rd_data[`VPC_BIT_ACTIVE] = q.active;
          n.rd_data[`VPC_BIT_READY] = (q.busy_cnt == 3'h0);
        end
        `VPC_OFF_VERSION: n.rd_data = {16'h0000, `VPC_VER_MAJOR, `VPC_VER_MINOR};
        `VPC_OFF_TRIG: n.rd_data = {31'h0000_0000, (q.busy_cnt != 3'h0)};
        `VPC_OFF_CTRL: n.rd_data = {30'h0000_0000, q.mix, q.enable};
        default: n.rd_data = 32'h0000_0000;
      endcase
    end

    // writes other than control are ignored while the processor is stopped
    if (wr && (q.enable || addr == `VPC_OFF_CTRL))
    begin
      case (addr)
        `VPC_OFF_FUNC: n.func = wr_data[15:0];
        `VPC_OFF_MASK: n.mask = wr_data[15:0];
        `VPC_OFF_ROM_START_ADDRESS: n.rom_start_address = wr_data;
        `VPC_OFF_ROM_BYTE_SIZE: n.rom_byte_size = wr_data;
        `VPC_OFF_KEY: n.key = wr_data;
        `VPC_OFF_CMD0: n.cmd[0] = wr_data[15:0];
        `VPC_OFF_CMD1: n.cmd[1] = wr_data[15:0];
        `VPC_OFF_SENT0: n.sent[0] = wr_data[15:0];
        `VPC_OFF_SENT1: n.sent[1] = wr_data[15:0];
        `VPC_OFF_VOL0: n.vol[0] = wr_data[15:0];
        `VPC_OFF_VOL1: n.vol[1] = wr_data[15:0];
        `VPC_OFF_REP0: n.rep[0] = wr_data[15:0];
        `VPC_OFF_REP1: n.rep[1] = wr_data[15:0];
        `VPC_OFF_SPEED: n.speed = wr_data[15:0];
        `VPC_OFF_PITCH: n.pitch = wr_data[15:0];
        `VPC_OFF_TRIG:
          if (wr_data[0] && q.busy_cnt == 3'h0)
            n.busy_cnt = `VPC_ISSUE_CYCLES;
        `VPC_OFF_CTRL:
        begin
          n.enable = wr_data[0];
          n.mix = wr_data[1];
        end
        default: n.func = n.func;
      endcase
    end

    if (q.busy_cnt != 3'h0)
      n.busy_cnt = q.busy_cnt - 3'h1;

    if (!q.enable)
    begin
      n.st[0] = ST_INITIAL;
      n.st[1] = ST_INITIAL;
      n.pend[0] = PD_NONE;
      n.pend[1] = PD_NONE;
      n.gap_cnt = '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (q.st[c] == ST_INITIAL && q.func[7:0] == `VPC_FUNC_PLAY)
          n.st[c] = ST_RESTING;

        // phrase boundary: pending actions first, then the loop count
        if (phrase_end[c] && (q.st[c] == ST_PLAYING || q.st[c] == ST_MUTED))
        begin
          n.pend[c] = PD_NONE;
          case (q.pend[c])
            PD_STOP: n.st[c] = ST_RESTING;
            PD_PAUSE: n.st[c] = ST_PAUSED;
            PD_MUTE: n.st[c] = ST_MUTED;
            default:
              if (q.loops[c] == 8'h01)
                n.st[c] = ST_RESTING;
              else
              begin
                if ({8'h00, q.loops[c]} != `VPC_REP_FOREVER)
                  n.loops[c] = q.loops[c] - 8'h01;
                if (q.gapless[c])
                  n.start[c] = 1'b1;
                else
                  n.gap_cnt[c] = 21'(GAP_CYCLES);
              end
          endcase
        end
        else if (q.gap_cnt[c] != 21'h0)
        begin
          n.gap_cnt[c] = q.gap_cnt[c] - 21'h1;
          if (q.gap_cnt[c] == 21'h1 && (q.st[c] == ST_PLAYING || q.st[c] == ST_MUTED))
            n.start[c] = 1'b1;
        end

        if (execute)
        begin
          if (q.func[7:0] != `VPC_FUNC_PLAY && q.func[7:0] != `VPC_FUNC_CHECK)
            e[`VPC_BIT_ERR_FUNC] = 1'b1;
          else if (q.func[7:0] == `VPC_FUNC_PLAY)
          begin
            if (q.cmd[c][15:8] > `VPC_OPT_GAPLESS)
              e[`VPC_BIT_ERR_CMD] = 1'b1;
            else
            begin
              case (q.cmd[c][7:0])
                `VPC_CMD_NOP: ok = 1'b1;
                `VPC_CMD_START:
                begin
                  ok = (q.st[c] == ST_RESTING);
                  if (ok && (q.vol[c] > `VPC_VOL_MAX || q.rep[c] == 16'h0000
                      || q.rep[c] > `VPC_REP_FOREVER
                      || (c == 0 && !rates_ok(q.speed, q.pitch))))
                    e[`VPC_BIT_ERR_OTHER] = 1'b1;
                  else if (ok)
                  begin
                    n.st[c] = ST_PLAYING;
                    n.loops[c] = q.rep[c][7:0];
                    n.phrase[c] = q.sent[c];
                    n.pend[c] = PD_NONE;
                    n.gap_cnt[c] = 21'h0;
                    n.start[c] = 1'b1;
                  end
                end
                `VPC_CMD_STOP_NOW:
                begin
                  ok = (q.st[c] == ST_PLAYING || q.st[c] == ST_PAUSED || q.st[c] == ST_MUTED);
                  if (ok)
                  begin
                    n.st[c] = ST_RESTING;
                    n.pend[c] = PD_NONE;
                    n.gap_cnt[c] = 21'h0;
                  end
                end
                `VPC_CMD_STOP_END:
                begin
                  ok = (q.st[c] == ST_PLAYING || q.st[c] == ST_MUTED);
                  if (ok)
                    n.pend[c] = PD_STOP;
                end
                `VPC_CMD_PAUSE_NOW:
                begin
                  ok = (q.st[c] == ST_PLAYING);
                  if (ok)
                    n.st[c] = ST_PAUSED;
                end
                `VPC_CMD_PAUSE_END:
                begin
                  ok = (q.st[c] == ST_PLAYING);
                  if (ok)
                    n.pend[c] = PD_PAUSE;
                end
                `VPC_CMD_RESUME:
                begin
                  ok = (q.st[c] == ST_PAUSED);
                  if (ok)
                    n.st[c] = ST_PLAYING;
                end
                `VPC_CMD_MUTE_NOW:
                begin
                  ok = (q.st[c] == ST_PLAYING);
                  if (ok)
                    n.st[c] = ST_MUTED;
                end
                `VPC_CMD_MUTE_END:
                begin
                  ok = (q.st[c] == ST_PLAYING);
                  if (ok)
                    n.pend[c] = PD_MUTE;
                end
                `VPC_CMD_UNMUTE:
                begin
                  ok = (q.st[c] == ST_MUTED);
                  if (ok)
                    n.st[c] = ST_PLAYING;
                end
                default: ok = 1'b0;
              endcase
              if (!ok)
                e[`VPC_BIT_ERR_CMD] = 1'b1;
            end
          end
        end
      end
    end

    // each issue replaces the error word; an error found now wins over that
    if (execute)
    begin
      n.err = e;
      n.err_evt = (e != 16'h0000);
    end

    for (int c = 0; c < 2; c++)
    begin
      if (n.st[c] != q.st[c])
      begin
        case (n.st[c])
          ST_RESTING: n.evt = n.evt | !q.mask[`VPC_BIT_M_REST];
          ST_PLAYING: n.evt = n.evt | !q.mask[`VPC_BIT_M_PLAY];
          ST_PAUSED: n.evt = n.evt | !q.mask[`VPC_BIT_M_PAUSE];
          ST_MUTED: n.evt = n.evt | !q.mask[`VPC_BIT_M_MUTE];
          default: n.evt = n.evt;
        endcase
      end
      n.gapless[c] = (n.cmd[c][15:8] == `VPC_OPT_GAPLESS) && !n.mix;
      n.lvl[c] = (n.st[c] == ST_MUTED) ? 8'h00 : n.vol[c][7:0];
    end
    n.active = (n.st[0] == ST_PLAYING) || (n.st[0] == ST_MUTED)
      || (n.st[1] == ST_PLAYING) || (n.st[1] == ST_MUTED);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.mask <= `VPC_MASK_RST;
      q.rep <= {`VPC_REP_RST, `VPC_REP_RST};
    end
    else
      q <= n;
  end

  assign rd_data = q.rd_data;
  assign phrase_start = q.start;
  assign ch0_phrase = q.phrase[0];
  assign ch1_phrase = q.phrase[1];
  assign ch0_level = q.lvl[0];
  assign ch1_level = q.lvl[1];
  assign gapless = q.gapless;
  assign output_active_flag = q.active;
  assign transition_evt = q.evt;
  assign error_evt = q.err_evt;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_issuing;
    (q.busy_cnt != 3'h0) [*4];
  endsequence
  property p_trigger;
    (wr && addr == `VPC_OFF_TRIG && wr_data[0] && q.busy_cnt == 3'h0 && q.enable)
      |=> s_issuing ##1 (q.busy_cnt == 3'h0);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger issue length wrong");
  property p_ready;
    rd && addr == `VPC_OFF_STATUS |=> rd_data[0] == ($past(q.busy_cnt) == 3'h0);
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit wrong");
  property p_active;
    rd && addr == `VPC_OFF_STATUS |=> rd_data[8] == $past(q.active);
  endproperty
  a_active: assert property (p_active) else $error("output active bit wrong");
  property p_bad_cmd;
    execute && q.enable && q.func[7:0] == `VPC_FUNC_PLAY && q.cmd[0][7:0] >= 8'h0A
      |=> q.err[0] && error_evt;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not flagged");
  property p_bad_opt;
    execute && q.enable && q.func[7:0] == `VPC_FUNC_PLAY
      && (q.cmd[0][15:8] >= 8'h02 || q.cmd[1][15:8] >= 8'h02) |=> q.err[0];
  endproperty
  a_bad_opt: assert property (p_bad_opt) else $error("bad option not flagged");
  property p_bad_func;
    execute && q.enable && q.func[7:0] != 8'h01 && q.func[7:0] != 8'h03 |=> q.err[14];
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("bad function not flagged");
  property p_bad_level;
    execute && q.enable && q.func[7:0] == `VPC_FUNC_PLAY && q.cmd[0][7:0] == `VPC_CMD_START
      && q.cmd[0][15:8] <= `VPC_OPT_GAPLESS && q.st[0] == ST_RESTING && q.vol[0] >= 16'h0080
      |=> q.err[15] && q.st[0] == ST_RESTING;
  endproperty
  a_bad_level: assert property (p_bad_level) else $error("bad level not flagged");
  property p_mix;
    q.mix |-> gapless == 2'b00;
  endproperty
  a_mix: assert property (p_mix) else $error("gapless while mixing");
  property p_mask;
    q.st[0] != $past(q.st[0]) && q.st[0] == ST_RESTING && !$past(q.mask[0]) |-> transition_evt;
  endproperty
  a_mask: assert property (p_mask) else $error("unmasked transition lost");
endmodule

// ===== inc/vpc_map.svh
// register offsets, field positions, codes and timing of the playback command block
`ifndef VPC_MAP_SVH
`define VPC_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define VPC_OFF_FUNC 8'h00
`define VPC_OFF_MASK 8'h02
`define VPC_OFF_ROM_START_ADDRESS 8'h04
`define VPC_OFF_ROM_BYTE_SIZE 8'h08
`define VPC_OFF_KEY 8'h0C
`define VPC_OFF_CMD0 8'h10
`define VPC_OFF_CMD1 8'h12
`define VPC_OFF_SENT0 8'h14
`define VPC_OFF_SENT1 8'h16
`define VPC_OFF_VOL0 8'h18
`define VPC_OFF_VOL1 8'h1A
`define VPC_OFF_REP0 8'h1C
`define VPC_OFF_REP1 8'h1E
`define VPC_OFF_SPEED 8'h20
`define VPC_OFF_PITCH 8'h24
`define VPC_OFF_STATE0 8'h40
`define VPC_OFF_STATE1 8'h42
`define VPC_OFF_ERROR 8'h44
`define VPC_OFF_STATUS 8'h46
`define VPC_OFF_VERSION 8'h4C
`define VPC_OFF_TRIG 8'h50
`define VPC_OFF_CTRL 8'h54

// ----------------------------------------
// field positions
// ----------------------------------------
`define VPC_BIT_READY 0
`define VPC_BIT_ACTIVE 8
`define VPC_BIT_ERR_CMD 0
`define VPC_BIT_ERR_FUNC 14
`define VPC_BIT_ERR_OTHER 15
`define VPC_BIT_M_REST 0
`define VPC_BIT_M_PLAY 1
`define VPC_BIT_M_PAUSE 2
`define VPC_BIT_M_MUTE 3

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define VPC_FUNC_PLAY 8'h01
`define VPC_FUNC_CHECK 8'h03
`define VPC_OPT_GAPLESS 8'h01
`define VPC_CMD_NOP 8'h00
`define VPC_CMD_START 8'h01
`define VPC_CMD_STOP_NOW 8'h02
`define VPC_CMD_STOP_END 8'h03
`define VPC_CMD_PAUSE_NOW 8'h04
`define VPC_CMD_PAUSE_END 8'h05
`define VPC_CMD_RESUME 8'h06
`define VPC_CMD_MUTE_NOW 8'h07
`define VPC_CMD_MUTE_END 8'h08
`define VPC_CMD_UNMUTE 8'h09
`define VPC_VOL_MAX 16'h007F
`define VPC_REP_FOREVER 16'h00FF
`define VPC_RATE_NORMAL 16'h0064
`define VPC_RATE_WIDE_LO 16'h004B
`define VPC_RATE_WIDE_HI 16'h007D
`define VPC_SPEED_PAIR_LO 16'h0055
`define VPC_SPEED_PAIR_HI 16'h0073
`define VPC_PITCH_PAIR_LO 16'h005A
`define VPC_PITCH_PAIR_HI 16'h006E
`define VPC_RATE_STEP 16'h0005
`define VPC_MASK_RST 16'h000F
`define VPC_REP_RST 16'h0001
// arbitrary revision values
`define VPC_VER_MAJOR 8'h01
`define VPC_VER_MINOR 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define VPC_CLK_KHZ 20000
`define VPC_GAP_MS 100
`define VPC_ISSUE_CYCLES 3'h4

`endif

// ===== inc/vpc_pkg.sv
// types shared by the playback command block
package vpc_pkg;
  typedef enum logic [2:0] {ST_INITIAL, ST_RESTING, ST_PLAYING, ST_PAUSED, ST_MUTED} vpc_st_t;
  typedef enum logic [1:0] {PD_NONE, PD_STOP, PD_PAUSE, PD_MUTE} vpc_pend_t;
  typedef struct packed {
    logic enable;
    logic mix;
    logic [15:0] func;
    logic [15:0] mask;
    logic [31:0] rom_start_address;
    logic [31:0] rom_byte_size;
    logic [31:0] key;
    logic [1:0][15:0] cmd;
    logic [1:0][15:0] sent;
    logic [1:0][15:0] vol;
    logic [1:0][15:0] rep;
    logic [15:0] speed;
    logic [15:0] pitch;
    logic [2:0] busy_cnt;
    vpc_st_t [1:0] st;
    vpc_pend_t [1:0] pend;
    logic [1:0][7:0] loops;
    logic [1:0][20:0] gap_cnt;
    logic [15:0] err;
    logic [31:0] rd_data;
    logic [1:0] start;
    logic [1:0][15:0] phrase;
    logic [1:0][7:0] lvl;
    logic [1:0] gapless;
    logic active;
    logic evt;
    logic err_evt;
  } vpc_state_t;
endpackage

// ===== testbench/vpc_engine_model.sv
// behavioural synthesis engine answering each phrase start with a phrase end
`timescale 1ns/1ps
module vpc_engine_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // phrase length select and handshake
  input wire logic slow,
  input wire logic [1:0] phrase_start,
  output logic [1:0] phrase_end
);
  int cnt [2];

  // ----------------------------------------
  // per-channel phrase timers
  // ----------------------------------------
  // ends only after a start, never unsolicited
  always @(posedge clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (rst)
      begin
        cnt[c] <= 0;
        phrase_end[c] <= 1'b0;
      end
      else if (phrase_start[c])
      begin
        cnt[c] <= slow ? 40 : 8;
        phrase_end[c] <= 1'b0;
      end
      else if (cnt[c] == 1)
      begin
        cnt[c] <= 0;
        phrase_end[c] <= 1'b1;
      end
      else
      begin
        phrase_end[c] <= 1'b0;
        if (cnt[c] > 1)
          cnt[c] <= cnt[c] - 1;
      end
    end
  end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the playback command register block
`timescale 1ns/1ps
`include "vpc_map.svh"
module testbench;
  import vpc_pkg::*;
  logic clk, rst, wr, rd, slow, rd_p;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, v;
  logic [1:0] phrase_end, phrase_start, gapless;
  logic [15:0] ch0_phrase, ch1_phrase;
  logic [7:0] ch0_level, ch1_level;
  logic output_active_flag, transition_evt, error_evt;
  int fails, comparisons, n_start, n_evt, n_err;
  logic [31:0] exp_q [$];
  string name_q [$];
  logic [7:0] seq_c [15] = '{1, 4, 6, 7, 9, 2, 1, 5, 2, 1, 8, 2, 1, 3, 0};
  logic [2:0] seq_s [15] = '{2, 3, 2, 4, 2, 1, 2, 3, 1, 2, 4, 1, 2, 1, 1};

  vpc_regs #(.GAP_CYCLES(20)) uut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr(wr), .rd(rd), .rd_data(rd_data), .phrase_end(phrase_end),
    .phrase_start(phrase_start), .ch0_phrase(ch0_phrase), .ch1_phrase(ch1_phrase),
    .ch0_level(ch0_level), .ch1_level(ch1_level), .gapless(gapless),
    .output_active_flag(output_active_flag), .transition_evt(transition_evt),
    .error_evt(error_evt));

  vpc_engine_model eng (.clk(clk), .rst(rst), .slow(slow), .phrase_start(phrase_start),
    .phrase_end(phrase_end));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // checking and reporting
  // ----------------------------------------
  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read data judged in the cycle after the strobe, oldest note first
  always @(posedge clk)
  begin
    if (rd_p === 1'b1 && exp_q.size() > 0)
      chk(name_q.pop_front(), exp_q.pop_front(), rd_data);
    rd_p <= rd;
    if (phrase_start[0] === 1'b1)
      n_start++;
    if (transition_evt === 1'b1)
      n_evt++;
    if (error_evt === 1'b1)
      n_err++;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_exp(logic [7:0] a, logic [31:0] e, string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // busy lasts four cycles after the trigger write
  task automatic cmd0(logic [15:0] c);
    wr_reg(`VPC_OFF_CMD0, c);
    wr_reg(`VPC_OFF_TRIG, 32'h1);
    repeat (6) @(posedge clk);
  endtask

  task automatic try(logic [7:0] a1, logic [15:0] d1, logic [7:0] a2, logic [15:0] d2,
                     logic [15:0] c, logic [15:0] e);
    wr_reg(a1, d1);
    wr_reg(a2, d2);
    cmd0(c);
    rd_exp(`VPC_OFF_ERROR, e, "error");
    cmd0(16'h0102);
  endtask

  initial
  begin
    #3000000;
    fails++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    slow = 1'b1;
    fails = 0;
    comparisons = 0;
    n_start = 0;
    n_evt = 0;
    void'($urandom(59));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_exp(`VPC_OFF_MASK, 32'h000F, "mask");
    rd_exp(`VPC_OFF_REP0, 32'h0001, "rep0");
    rd_exp(`VPC_OFF_STATE0, 32'h0, "state0");
    rd_exp(`VPC_OFF_VERSION, 32'h0100, "version");
    rd_exp(8'h30, 32'h0, "unmapped");
    wr_reg(`VPC_OFF_SENT0, 32'h1234);
    rd_exp(`VPC_OFF_SENT0, 32'h0, "sent0_off");
    wr_reg(`VPC_OFF_CTRL, 32'h1);
    wr_reg(`VPC_OFF_FUNC, 32'h0001);
    repeat (4) @(posedge clk);
    rd_exp(`VPC_OFF_STATE0, 32'h1, "state0");
    rd_exp(`VPC_OFF_STATUS, 32'h1, "status");
    wr_reg(`VPC_OFF_ROM_START_ADDRESS, 32'h0002FFF0);
    wr_reg(`VPC_OFF_ROM_BYTE_SIZE, 32'h00030000);
    v = $urandom();
    wr_reg(`VPC_OFF_KEY, v);
    rd_exp(`VPC_OFF_KEY, v, "key");
    rd_exp(`VPC_OFF_ROM_START_ADDRESS, 32'h0002FFF0, "rom_start_address");
    wr_reg(`VPC_OFF_ROM_START_ADDRESS, 32'h00140000);
    rd_exp(`VPC_OFF_ROM_START_ADDRESS, 32'h00140000, "rom_start_address_ext");
    // gapless start, two loops, slow phrases
    v = {16'h0, 16'($urandom())};
    wr_reg(`VPC_OFF_SENT0, v);
    wr_reg(`VPC_OFF_VOL0, 32'h0040);
    wr_reg(`VPC_OFF_REP0, 32'h0002);
    wr_reg(`VPC_OFF_SPEED, 32'h0064);
    wr_reg(`VPC_OFF_CMD0, 32'h0101);
    n_start = 0;
    wr_reg(`VPC_OFF_TRIG, 32'h1);
    rd_exp(`VPC_OFF_TRIG, 32'h1, "trig_busy");
    rd_exp(`VPC_OFF_STATUS, 32'h0, "status_busy");
    repeat (4) @(posedge clk);
    rd_exp(`VPC_OFF_STATE0, 32'h2, "state0");
    rd_exp(`VPC_OFF_STATUS, 32'h0101, "status");
    rd_exp(`VPC_OFF_ERROR, 32'h0, "error");
    chk("ch0_phrase", v, {16'h0, ch0_phrase});
    chk("ch0_level", 32'h40, {24'h0, ch0_level});
    chk("gapless", 32'h1, {30'h0, gapless});
    repeat (120) @(posedge clk);
    chk("starts", 32'd2, n_start);
    rd_exp(`VPC_OFF_STATE0, 32'h1, "state0");
    // silent gap between phrases with fast phrases
    slow <= 1'b0;
    n_start = 0;
    cmd0(16'h0001);
    repeat (14) @(posedge clk);
    chk("starts_gap", 32'd1, n_start);
    repeat (30) @(posedge clk);
    chk("starts_gap", 32'd2, n_start);
    // every command code, looping forever
    slow <= 1'b1;
    wr_reg(`VPC_OFF_REP0, 32'h00FF);
    for (int i = 0; i < 15; i++)
    begin
      cmd0({8'h01, seq_c[i]});
      repeat (100) @(posedge clk);
      rd_exp(`VPC_OFF_STATE0, seq_s[i], "state0");
      rd_exp(`VPC_OFF_STATUS, (seq_s[i] == 2 || seq_s[i] == 4) ? 32'h101 : 32'h1, "status");
      if (seq_s[i] == 4)
        chk("ch0_level", 32'h0, {24'h0, ch0_level});
    end
    // refused codes and parameter ranges
    n_err = 0;
    try(`VPC_OFF_CMD0, 16'h0, `VPC_OFF_CMD0, 16'h0, 16'h000A, 16'h0001);
    chk("error_events", 32'd2, n_err);
    v = 32'h0B + ($urandom() % 32'hF5);
    try(`VPC_OFF_CMD0, 16'h0, `VPC_OFF_CMD0, 16'h0, v[15:0], 16'h0001);
    try(`VPC_OFF_CMD0, 16'h0, `VPC_OFF_CMD0, 16'h0, 16'h0201, 16'h0001);
    try(`VPC_OFF_VOL0, 16'h0080, `VPC_OFF_REP0, 16'h00FF, 16'h0101, 16'h8000);
    try(`VPC_OFF_VOL0, 16'h007F, `VPC_OFF_REP0, 16'h0000, 16'h0101, 16'h8000);
    try(`VPC_OFF_REP0, 16'h00FF, `VPC_OFF_PITCH, 16'h0064, 16'h0101, 16'h0000);
    try(`VPC_OFF_SPEED, 16'h0050, `VPC_OFF_PITCH, 16'h0064, 16'h0101, 16'h8000);
    try(`VPC_OFF_SPEED, 16'h0073, `VPC_OFF_PITCH, 16'h006E, 16'h0101, 16'h0000);
    try(`VPC_OFF_SPEED, 16'h0064, `VPC_OFF_PITCH, 16'h0055, 16'h0101, 16'h8000);
    try(`VPC_OFF_SPEED, 16'h007D, `VPC_OFF_PITCH, 16'h0000, 16'h0101, 16'h0000);
    try(`VPC_OFF_SPEED, 16'h007E, `VPC_OFF_PITCH, 16'h0000, 16'h0101, 16'h8000);
    try(`VPC_OFF_SPEED, 16'h0000, `VPC_OFF_PITCH, 16'h004B, 16'h0101, 16'h0000);
    try(`VPC_OFF_PITCH, 16'h0000, `VPC_OFF_SPEED, 16'h0064, 16'h0101, 16'h0000);
    try(`VPC_OFF_FUNC, 16'h0003, `VPC_OFF_CMD0, 16'h0, 16'h0001, 16'h0000);
    try(`VPC_OFF_FUNC, 16'h0005, `VPC_OFF_CMD0, 16'h0, 16'h0000, 16'h4000);
    wr_reg(`VPC_OFF_FUNC, 32'h0001);
    // unmasked entries to playing and to resting each raise one event
    wr_reg(`VPC_OFF_MASK, 32'h000C);
    n_evt = 0;
    cmd0(16'h0101);
    chk("events", 32'd1, n_evt);
    cmd0(16'h0102);
    chk("events", 32'd2, n_evt);
    // two-channel mix drops gapless on both
    wr_reg(`VPC_OFF_CTRL, 32'h3);
    wr_reg(`VPC_OFF_SENT1, v);
    wr_reg(`VPC_OFF_CMD1, 32'h0101);
    wr_reg(`VPC_OFF_VOL1, 32'h0033);
    cmd0(16'h0101);
    chk("gapless_mix", 32'h0, {30'h0, gapless});
    chk("ch1_level", 32'h33, {24'h0, ch1_level});
    chk("active", 32'h1, {31'h0, output_active_flag});
    chk("ch1_phrase", {16'h0, v[15:0]}, {16'h0, ch1_phrase});
    rd_exp(`VPC_OFF_STATE1, 32'h2, "state1");
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
